//--- inc/pfc_defines.vh
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// Register word offsets (byte addresses)
`define PFC_OFS_ROUTE7    8'h00
`define PFC_OFS_PCLK1     8'h04
`define PFC_OFS_START     8'h08
`define PFC_OFS_MASK2H    8'h0c
`define PFC_OFS_IRQF2H    8'h10
`define PFC_OFS_ELC       8'h14
`define PFC_OFS_MODE      8'h18
`define PFC_OFS_PWMSEL    8'h1c
`define PFC_OFS_CUTSEL    8'h20
`define PFC_OFS_OUTOFF    8'h24
`define PFC_OFS_INITLVL   8'h28
`define PFC_OFS_CTRL0     8'h2c
`define PFC_OFS_ACTLVL    8'h30
`define PFC_OFS_GRA       8'h34
`define PFC_OFS_GRB       8'h38
`define PFC_OFS_GRC       8'h3c
`define PFC_OFS_GRD       8'h40
`define PFC_OFS_COUNT     8'h44
`define PFC_OFS_STATUS    8'h48

// Field positions
`define PFC_LINK_CODE_CUT 4'h6
`define PFC_BIT_CLK_GATE  4
`define PFC_BIT_CONTINUE  2
`define PFC_BIT_START0    0
`define PFC_BIT_IRQ0      1
`define PFC_BIT_CUT_EN    1
`define PFC_BIT_BUF_D     5
`define PFC_BIT_BUF_C     4
`define PFC_BIT_PWM_B     0
`define PFC_BIT_INIT_B    1
`define PFC_BIT_POL_B     0
`define PFC_CUT_OFF       2'h0
`define PFC_CUT_HIZ       2'h1
`define PFC_CUT_LOW       2'h2
`define PFC_CUT_HIGH      2'h3
`define PFC_CLR_GRA       3'h1

// Reset values
`define PFC_RST_BYTE      8'h00
`define PFC_RST_OUTOFF    8'h0f
`define PFC_RST_GR        16'hffff

`endif

//--- src/pfc_top.v
// Functional notes
// - Event input 7 is the clock alarm or fixed-cycle detection pulse.
// - Link code 0 disables routing; code 0110 routes event to cutoff.
// - Clock gate bit 4 low holds timer in reset and blocks timer register writes.
// - Continue bit 0 stops count at period match; 1 keeps counting.
// - Start bit 0 written 1 starts counter, written 0 stops it.
// - Mask bit 1 low enables servicing; flag bit 1 shows pending request.
// - Cutoff enable bit 1 lets routed event force pulse output cutoff.
// - Mode bit 5 makes register D the buffer of register B.
// - Mode bit 4 makes register C the buffer of register A.
// - PWM select bit 0 picks PWM on pin B, else compare.
// - Pin B cutoff code: 00 off, 01 high-z, 10 low, 11 high.
// - Pin C cutoff uses bits 3:2 with the same coding.
// - Pin D cutoff uses bits 1:0 with the same coding.
// - Output off bits 3..0 release pins D..A to general I/O.
// - Pin B initial level bit 1 low gives low initial output in compare mode, inactive level in PWM.
// - Register A holds period; counter clears on its match when clear select is 001.
// - Register B holds the pin B level change point.
// - Pin B active level bit: 0 active low, 1 active high.
// - Clear select code 001 clears counter on register A match.
`timescale 1ns/1ps
`include "pfc_defines.vh"

module pfc_top #(
    parameter CW = 16
) (
    // Clock and reset
    input  wire          i_sys_clk,
    input  wire          i_rst,
    // Wishbone slave
    input  wire          i_wb_cyc,
    input  wire          i_wb_stb,
    input  wire          i_wb_we,
    input  wire [7:0]    i_wb_adr,
    input  wire [3:0]    i_wb_sel,
    input  wire [31:0]   i_wb_dat,
    output reg  [31:0]   o_wb_dat,
    output reg           o_wb_ack,
    // Event source
    input  wire          i_clock_alarm_interrupt,
    // Timer pins
    output reg  [3:0]    o_pin_out,
    output reg  [3:0]    o_pin_oe,
    output reg  [3:0]    o_pin_timer_owned,
    // Interrupt request toward controller
    output reg           o_timer_irq_req
);

    reg [7:0]    route_q;
    reg [7:0]    pclk_q;
    reg [7:0]    start_q;
    reg [7:0]    mask_q;
    reg [7:0]    irqf_q;
    reg [7:0]    elc_q;
    reg [7:0]    mode_q;
    reg [7:0]    pwmsel_q;
    reg [7:0]    cutsel_q;
    reg [7:0]    outoff_q;
    reg [7:0]    initlvl_q;
    reg [7:0]    ctrl0_q;
    reg [7:0]    actlvl_q;
    reg [CW-1:0] gra_q;
    reg [CW-1:0] grb_q;
    reg [CW-1:0] grc_q;
    reg [CW-1:0] grd_q;
    reg [CW-1:0] cnt_q;
    reg          cut_q;
    reg          pwm_b_q;
    reg          match_a_q;

    wire         wr_req;
    wire         gate;
    wire         wr_ok;
    wire         run;
    wire         hit_a;
    wire         hit_b;
    wire         evt_cut;
    wire [1:0]   code_b;
    wire [1:0]   code_c;
    wire [1:0]   code_d;
    reg  [31:0]  rd_d;

    assign wr_req = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];
    assign gate   = pclk_q[`PFC_BIT_CLK_GATE];
    assign wr_ok  = wr_req & gate;
    assign run    = gate & start_q[`PFC_BIT_START0];
    assign hit_a  = run & (cnt_q == gra_q);
    assign hit_b  = run & (cnt_q == grb_q);
    assign evt_cut = i_clock_alarm_interrupt & gate &
                     (route_q[3:0] == `PFC_LINK_CODE_CUT) &
                     elc_q[`PFC_BIT_CUT_EN];
    assign code_b = cutsel_q[5:4];
    assign code_c = cutsel_q[3:2];
    assign code_d = cutsel_q[1:0];

    // Global registers outside the timer clock gate
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            route_q <= `PFC_RST_BYTE;
            pclk_q  <= `PFC_RST_BYTE;
            mask_q  <= 8'hff;
        end else if (wr_req) begin
            case (i_wb_adr)
                `PFC_OFS_ROUTE7: route_q <= {4'h0, i_wb_dat[3:0]};
                `PFC_OFS_PCLK1:  pclk_q  <= i_wb_dat[7:0];
                `PFC_OFS_MASK2H: mask_q  <= i_wb_dat[7:0];
                default:         route_q <= route_q;
            endcase
        end
    end

    // Timer registers, held in reset while the clock gate is off
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            start_q   <= `PFC_RST_BYTE;
            elc_q     <= `PFC_RST_BYTE;
            mode_q    <= `PFC_RST_BYTE;
            pwmsel_q  <= `PFC_RST_BYTE;
            cutsel_q  <= `PFC_RST_BYTE;
            outoff_q  <= `PFC_RST_OUTOFF;
            initlvl_q <= `PFC_RST_BYTE;
            ctrl0_q   <= `PFC_RST_BYTE;
            actlvl_q  <= `PFC_RST_BYTE;
            gra_q     <= `PFC_RST_GR;
            grb_q     <= `PFC_RST_GR;
            grc_q     <= `PFC_RST_GR;
            grd_q     <= `PFC_RST_GR;
        end else if (!gate) begin
            start_q   <= `PFC_RST_BYTE;
            elc_q     <= `PFC_RST_BYTE;
            mode_q    <= `PFC_RST_BYTE;
            pwmsel_q  <= `PFC_RST_BYTE;
            cutsel_q  <= `PFC_RST_BYTE;
            outoff_q  <= `PFC_RST_OUTOFF;
            initlvl_q <= `PFC_RST_BYTE;
            ctrl0_q   <= `PFC_RST_BYTE;
            actlvl_q  <= `PFC_RST_BYTE;
            gra_q     <= `PFC_RST_GR;
            grb_q     <= `PFC_RST_GR;
            grc_q     <= `PFC_RST_GR;
            grd_q     <= `PFC_RST_GR;
        end else begin
            if (hit_a && !start_q[`PFC_BIT_CONTINUE])
                start_q[`PFC_BIT_START0] <= 1'b0;
            if (hit_a && mode_q[`PFC_BIT_BUF_C])
                gra_q <= grc_q;
            if (hit_a && mode_q[`PFC_BIT_BUF_D])
                grb_q <= grd_q;
            if (wr_ok) begin
                case (i_wb_adr)
                    `PFC_OFS_START:   start_q   <= {5'h0, i_wb_dat[2:0]};
                    `PFC_OFS_ELC:     elc_q     <= i_wb_dat[7:0] & 8'h33;
                    `PFC_OFS_MODE:    mode_q    <= i_wb_dat[7:0] & 8'hf1;
                    `PFC_OFS_PWMSEL:  pwmsel_q  <= i_wb_dat[7:0] & 8'h77;
                    `PFC_OFS_CUTSEL:  cutsel_q  <= i_wb_dat[7:0];
                    `PFC_OFS_OUTOFF:  outoff_q  <= i_wb_dat[7:0];
                    `PFC_OFS_INITLVL: initlvl_q <= i_wb_dat[7:0];
                    `PFC_OFS_CTRL0:   ctrl0_q   <= i_wb_dat[7:0];
                    `PFC_OFS_ACTLVL:  actlvl_q  <= i_wb_dat[7:0] & 8'h07;
                    `PFC_OFS_GRA:     gra_q     <= i_wb_dat[CW-1:0];
                    `PFC_OFS_GRB:     grb_q     <= i_wb_dat[CW-1:0];
                    `PFC_OFS_GRC:     grc_q     <= i_wb_dat[CW-1:0];
                    `PFC_OFS_GRD:     grd_q     <= i_wb_dat[CW-1:0];
                    default:          elc_q     <= elc_q;
                endcase
            end
        end
    end

    // Counter and pin B waveform
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q     <= {CW{1'b0}};
            pwm_b_q   <= 1'b0;
            match_a_q <= 1'b0;
        end else if (!gate) begin
            cnt_q     <= {CW{1'b0}};
            pwm_b_q   <= 1'b0;
            match_a_q <= 1'b0;
        end else begin
            match_a_q <= hit_a;
            if (!run) begin
                if (!start_q[`PFC_BIT_START0])
                    pwm_b_q <= initlvl_q[`PFC_BIT_INIT_B];
            end else begin
                if (hit_a && ctrl0_q[7:5] == `PFC_CLR_GRA)
                    cnt_q <= {CW{1'b0}};
                else
                    cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
                // active at period, inactive at B
                if (hit_a)
                    pwm_b_q <= 1'b1;
                else if (hit_b)
                    pwm_b_q <= 1'b0;
            end
        end
    end

    // Cutoff latch, released by writing 0 to start bit 0 or by the gate going off
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            cut_q <= 1'b0;
        else if (!gate)
            cut_q <= 1'b0;
        else if (evt_cut)
            cut_q <= 1'b1;
        else if (wr_ok && i_wb_adr == `PFC_OFS_START && !i_wb_dat[0])
            cut_q <= 1'b0;
    end

    // Interrupt request flag: set wins over clear
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            irqf_q <= `PFC_RST_BYTE;
        else begin
            if (wr_req && i_wb_adr == `PFC_OFS_IRQF2H)
                irqf_q <= i_wb_dat[7:0];
            if (match_a_q)
                irqf_q[`PFC_BIT_IRQ0] <= 1'b1;
        end
    end

    function [1:0] pin_drive;
        input [1:0] code;
        input       cut;
        input       lvl;
        begin
            pin_drive = {1'b1, lvl};
            if (cut) begin
                case (code)
                    `PFC_CUT_HIZ:  pin_drive = 2'b00;
                    `PFC_CUT_LOW:  pin_drive = 2'b10;
                    `PFC_CUT_HIGH: pin_drive = 2'b11;
                    default:       pin_drive = {1'b1, lvl};
                endcase
            end
        end
    endfunction

    wire       b_lvl;
    wire [1:0] drv_b;
    wire [1:0] drv_c;
    wire [1:0] drv_d;
    // PWM level with polarity, or compare level as is
    assign b_lvl = pwmsel_q[`PFC_BIT_PWM_B] ?
                   (pwm_b_q ~^ actlvl_q[`PFC_BIT_POL_B]) : pwm_b_q;
    assign drv_b = pin_drive(code_b, cut_q, b_lvl);
    assign drv_c = pin_drive(code_c, cut_q, 1'b0);
    assign drv_d = pin_drive(code_d, cut_q, 1'b0);

    // Pin and irq outputs
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin_out         <= 4'h0;
            o_pin_oe          <= 4'h0;
            o_pin_timer_owned <= 4'h0;
            o_timer_irq_req   <= 1'b0;
        end else begin
            o_pin_out <= {drv_d[0], drv_c[0], drv_b[0], 1'b0};
            o_pin_oe  <= {drv_d[1], drv_c[1], drv_b[1], 1'b1} &
                         ~outoff_q[3:0] & {4{gate}};
            o_pin_timer_owned <= ~outoff_q[3:0] & {4{gate}};
            o_timer_irq_req <= irqf_q[`PFC_BIT_IRQ0] &
                               ~mask_q[`PFC_BIT_IRQ0];
        end
    end

    always @* begin
        rd_d = 32'h0;
        case (i_wb_adr)
            `PFC_OFS_ROUTE7:  rd_d[7:0] = route_q;
            `PFC_OFS_PCLK1:   rd_d[7:0] = pclk_q;
            `PFC_OFS_START:   rd_d[7:0] = start_q;
            `PFC_OFS_MASK2H:  rd_d[7:0] = mask_q;
            `PFC_OFS_IRQF2H:  rd_d[7:0] = irqf_q;
            `PFC_OFS_ELC:     rd_d[7:0] = elc_q;
            `PFC_OFS_MODE:    rd_d[7:0] = mode_q;
            `PFC_OFS_PWMSEL:  rd_d[7:0] = pwmsel_q;
            `PFC_OFS_CUTSEL:  rd_d[7:0] = cutsel_q;
            `PFC_OFS_OUTOFF:  rd_d[7:0] = outoff_q;
            `PFC_OFS_INITLVL: rd_d[7:0] = initlvl_q;
            `PFC_OFS_CTRL0:   rd_d[7:0] = ctrl0_q;
            `PFC_OFS_ACTLVL:  rd_d[7:0] = actlvl_q;
            `PFC_OFS_GRA:     rd_d[CW-1:0] = gra_q;
            `PFC_OFS_GRB:     rd_d[CW-1:0] = grb_q;
            `PFC_OFS_GRC:     rd_d[CW-1:0] = grc_q;
            `PFC_OFS_GRD:     rd_d[CW-1:0] = grd_q;
            `PFC_OFS_COUNT:   rd_d[CW-1:0] = cnt_q;
            `PFC_OFS_STATUS:  rd_d[1:0] = {pwm_b_q, cut_q};
            default:          rd_d = 32'h0;
        endcase
    end

    // Bus answer one cycle after request
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
            o_wb_dat <= rd_d;
        end
    end

endmodule

//--- verification/pfc_alarm_src.sv
`timescale 1ns/1ps
module pfc_alarm_src (
    // Clock and reset
    input  wire       i_sys_clk,
    input  wire       i_rst,
    // Request: cycles to wait before the alarm fires
    input  wire       i_fire,
    input  wire [3:0] i_delay,
    // Detection pulse toward the timer
    output reg        o_alarm
);
    reg [4:0] cnt_q;

    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q   <= 5'h00;
            o_alarm <= 1'b0;
        end else begin
            o_alarm <= (cnt_q == 5'h01);
            if (i_fire)
                cnt_q <= {1'b0, i_delay} + 5'h01;
            else if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
        end
    end
endmodule

//--- verification/pfc_top_asserts.sv
`timescale 1ns/1ps
`include "pfc_defines.vh"
module pfc_top_asserts (
    // Clock and reset
    input logic        i_sys_clk,
    input logic        i_rst,
    // Bus
    input logic        i_wb_cyc,
    input logic        i_wb_stb,
    input logic        i_wb_we,
    input logic [7:0]  i_wb_adr,
    input logic [31:0] i_wb_dat,
    input logic        o_wb_ack,
    // Event and pins
    input logic        i_clock_alarm_interrupt,
    input logic [3:0]  o_pin_out,
    input logic [3:0]  o_pin_oe,
    input logic [3:0]  o_pin_timer_owned,
    input logic        o_timer_irq_req
);
    // Shadow of written registers, one byte per word offset
    logic [7:0] sh_q [0:18];
    logic [2:0] quiet_q;
    wire        wr   = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
    wire [4:0]  idx  = i_wb_adr[6:2];
    wire        gate = sh_q[1][`PFC_BIT_CLK_GATE];
    wire        ok   = quiet_q > 3'd2;
    wire [1:0]  cut  = sh_q[8][5:4];
    wire        ev   = i_clock_alarm_interrupt && gate && ok
                       && sh_q[0][3:0] == `PFC_LINK_CODE_CUT
                       && sh_q[5][`PFC_BIT_CUT_EN] && o_pin_timer_owned[1];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 19; i++)
                sh_q[i] <= (i == 3) ? 8'hff : (i == 9) ? 8'h0f : 8'h00;
            quiet_q <= 3'h0;
        end else begin
            quiet_q <= wr ? 3'h0
                       : (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
            if (!gate) begin
                sh_q[5] <= 8'h00;
                sh_q[8] <= 8'h00;
                sh_q[9] <= `PFC_RST_OUTOFF;
            end
            if (wr && !i_wb_adr[7] && idx < 5'd19 && (gate || idx < 5'd5))
                sh_q[idx] <= i_wb_dat[7:0];
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    ack_follow_a: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered next cycle");
    ack_single_a: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    gate_hold_a: assert property (
        !gate && ok |-> o_pin_oe == 4'h0)
        else $error("pin driven with clock gate off");
    owned_match_a: assert property (
        ok |-> o_pin_timer_owned == ({4{gate}} & ~sh_q[9][3:0]))
        else $error("pin ownership differs from output off bits");
    oe_owned_a: assert property (
        (o_pin_oe & ~o_pin_timer_owned) == 4'h0)
        else $error("released pin still driven");
    mask_quiet_a: assert property (
        ok && sh_q[3][`PFC_BIT_IRQ0] |-> !o_timer_irq_req)
        else $error("masked request reaches output");
    cut_hiz_a: assert property (
        ev && cut == `PFC_CUT_HIZ |-> ##[1:3] !o_pin_oe[1])
        else $error("pin B not high impedance after event");
    cut_low_a: assert property (
        ev && cut == `PFC_CUT_LOW |-> ##[1:3] o_pin_oe[1] && !o_pin_out[1])
        else $error("pin B not driven low after event");
    cut_high_a: assert property (
        ev && cut == `PFC_CUT_HIGH |-> ##[1:3] o_pin_oe[1] && o_pin_out[1])
        else $error("pin B not driven high after event");

    cover property (ev);
    cover property ($rose(o_timer_irq_req));
    cover property (wr && idx == 5'd1);
endmodule

//--- verification/test_pwm_forced_cutoff_event_link.sv
`timescale 1ns/1ps
`include "pfc_defines.vh"
module test_pwm_forced_cutoff_event_link;
    logic        clk, rst, cyc, stb, we, fire;
    logic [3:0]  dly;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat;
    wire  [31:0] dat;
    wire         ack, alarm, irq;
    wire  [3:0]  pout, poe, pown;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;

    pfc_top #(.CW(16)) DUT (
        .i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat),
        .o_wb_dat(dat), .o_wb_ack(ack), .i_clock_alarm_interrupt(alarm),
        .o_pin_out(pout), .o_pin_oe(poe), .o_pin_timer_owned(pown),
        .o_timer_irq_req(irq));
    pfc_alarm_src u_alarm (.i_sys_clk(clk), .i_rst(rst), .i_fire(fire),
                           .i_delay(dly), .o_alarm(alarm));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            final_report;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rdat = dat;
        if (ack !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: no bus answer", $time);
        end
        {cyc, stb, we} <= 3'h0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic alarm_after(input logic [3:0] d);
        {fire, dly} <= {1'b1, d};
        @(posedge clk);
        fire <= 1'b0;
        tick(20);
    endtask

    task automatic t_resets;
        rd(`PFC_OFS_MASK2H, 32'hff);
        wb(1'b1, `PFC_OFS_OUTOFF, 32'h0);
        rd(`PFC_OFS_OUTOFF, 32'h0f);
        rd(`PFC_OFS_GRA, 32'hffff);
        rd(8'h80, 32'h0);
        check({28'h0, pown}, 32'h0);
    endtask

    task automatic t_setup;
        wb(1'b1, `PFC_OFS_PCLK1, 32'h10);
        wb(1'b1, `PFC_OFS_GRA, 32'hc);
        wb(1'b1, `PFC_OFS_GRB, 32'h5);
        wb(1'b1, `PFC_OFS_PWMSEL, 32'h1);
        wb(1'b1, `PFC_OFS_CTRL0, 32'h20);
        wb(1'b1, `PFC_OFS_ACTLVL, 32'h1);
        wb(1'b1, `PFC_OFS_OUTOFF, 32'h2);
        tick(3);
        check({27'h0, poe[1], pown}, 32'hd);
        wb(1'b1, `PFC_OFS_OUTOFF, 32'h0);
        tick(3);
        check({28'h0, pown}, 32'hf);
    endtask

    task automatic t_init;
        for (int lv = 0; lv < 2; lv++) begin
            wb(1'b1, `PFC_OFS_INITLVL, 32'(lv * 2));
            tick(3);
            check({30'h0, poe[1], pout[1]}, 32'(2 + lv));
        end
    endtask

    // Start codes in turn: stop at match, run on, stopped
    task automatic t_count;
        logic [31:0] c0;
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `PFC_OFS_START, 32'({i == 1, 1'b0, i < 2}));
            tick(30);
            wb(1'b0, `PFC_OFS_COUNT, 32'h0);
            c0 = rdat;
            tick(6);
            wb(1'b0, `PFC_OFS_COUNT, 32'h0);
            check({31'h0, rdat !== c0}, 32'(i == 1));
        end
    endtask

    task automatic t_irq;
        int n;
        wb(1'b1, `PFC_OFS_IRQF2H, 32'h0);
        rd(`PFC_OFS_IRQF2H, 32'h0);
        wb(1'b1, `PFC_OFS_MASK2H, 32'hfd);
        tick(2);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, `PFC_OFS_START, 32'h5);
        for (n = 0; n < 40 && irq !== 1'b1; n++)
            @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd(`PFC_OFS_IRQF2H, 32'h2);
        wb(1'b1, `PFC_OFS_START, 32'h0);
        wb(1'b1, `PFC_OFS_IRQF2H, 32'h0);
        tick(2);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, `PFC_OFS_MASK2H, 32'hff);
    endtask

    task automatic t_cut;
        wb(1'b1, `PFC_OFS_ROUTE7, 32'(`PFC_LINK_CODE_CUT));
        wb(1'b1, `PFC_OFS_ELC, 32'h2);
        for (int c = 1; c < 4; c++) begin
            wb(1'b1, `PFC_OFS_START, 32'h0);
            wb(1'b1, `PFC_OFS_CUTSEL, 32'(c * 8'h15));
            wb(1'b1, `PFC_OFS_START, 32'h5);
            alarm_after(4'(c * 3));
            check({26'h0, poe[3:1], pout[3:1]},
                  32'({{3{c > 1}}, {3{c == 3}}}));
        end
    endtask

    // Link off, then cutoff enable off: pin B must keep toggling
    task automatic t_nocut;
        logic [1:0] seen;
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, `PFC_OFS_START, 32'h0);
            wb(1'b1, `PFC_OFS_ROUTE7, k ? 32'h6 : 32'h0);
            wb(1'b1, `PFC_OFS_ELC, k ? 32'h0 : 32'h2);
            wb(1'b1, `PFC_OFS_START, 32'h5);
            alarm_after(4'h0);
            seen = 2'b00;
            repeat (30) begin
                @(posedge clk);
                seen[pout[1]] = 1'b1;
            end
            check({30'h0, seen}, 32'h3);
        end
    endtask

    initial begin
        {rst, cyc, stb, we, fire} = 5'h10;
        {dly, adr, wdat} = 44'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_resets;
        t_setup;
        t_init;
        t_count;
        t_irq;
        t_cut;
        t_nocut;
        final_report;
    end
endmodule

bind pfc_top pfc_top_asserts u_chk (
    .i_sys_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_dat, .o_wb_ack, .i_clock_alarm_interrupt, .o_pin_out,
    .o_pin_oe, .o_pin_timer_owned, .o_timer_irq_req);
